// >>> verilog/spisg_top.sv
// spi select handling and transfer gating, master and slave
`timescale 1ns/1ns
`default_nettype none
module spisg_top
    import spisg_pkg::*;
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // serial pins
    input  wire logic        sck_in,
    input  wire logic        ss_in,
    input  wire logic        sdi,
    output var  logic        sck_out,
    output var  logic        sck_oe,
    output var  logic        sdo,
    output var  logic        sdo_oe
);
    logic [11:0]  ctrl_reg;
    logic [2:0]   width_reg;
    logic [15:0]  count_reg;
    logic [7:0]   tx_reg;
    logic         tx_full_reg;
    logic [7:0]   rx_reg;
    logic         rx_has_reg;
    logic         fault_reg;
    logic [7:0]   shift_reg;
    logic [2:0]   bit_reg;
    logic [7:0]   last_rx_reg;
    logic         busy_reg;
    logic [3:0]   div_reg;
    logic         sck_s_reg;
    spisg_state_t state_reg;
    logic [2:0]   pins_s;
    logic         en, mst, burst_count_mode, cke, clock_idle_polarity;

    assign en    = ctrl_reg[CTRL_EN];
    assign mst   = ctrl_reg[CTRL_MST];
    assign burst_count_mode = ctrl_reg[CTRL_BURST_COUNT_MODE];
    assign cke   = ctrl_reg[CTRL_CKE];
    assign clock_idle_polarity   = ctrl_reg[CTRL_CKP];

    spisg_sync #(.W(3)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d_in    ({sdi, ss_in, sck_in}),
        .q_out   (pins_s)
    );

    // effective select: polarity then force
    logic sel_act;
    assign sel_act = ctrl_reg[CTRL_SELECT_FORCE_ACTIVE] |
                     (pins_s[1] ^ ctrl_reg[CTRL_SSP]);

    // slave clock edges after polarity; ignored while deselected
    logic sck_lvl, sck_rise, sck_fall, slv_on;
    assign sck_lvl  = pins_s[0] ^ clock_idle_polarity;
    assign slv_on   = en & ~mst & sel_act;
    assign sck_rise = slv_on & sck_lvl & ~sck_s_reg;
    assign sck_fall = slv_on & ~sck_lvl & sck_s_reg;

    logic sel_prev_reg;
    logic sel_drop;
    assign sel_drop = sel_prev_reg & ~sel_act & en & ~mst;

    // sample edge: leading (rising) edge whatever cke, shift out on falling edge
    logic smp_edge, out_edge;
    assign smp_edge = cke ? sck_rise : sck_rise;
    assign out_edge = sck_fall;

    // master gating
    logic transmit_path_enable, receive_store_enable, cnt_nz, go;
    assign transmit_path_enable    = ctrl_reg[CTRL_TXR];
    assign receive_store_enable    = ctrl_reg[CTRL_RXR];
    assign cnt_nz = count_reg != 16'h0000;
    always_comb begin
        case ({transmit_path_enable, receive_store_enable})
            2'b11: go = ~rx_has_reg & tx_full_reg &
                        (burst_count_mode | cnt_nz);
            2'b01: go = ~rx_has_reg & cnt_nz;
            2'b10: go = tx_full_reg & (burst_count_mode | cnt_nz);
            default: go = 1'b0;
        endcase
    end

    // index of the last bit in the final word when count reaches last
    function automatic logic [2:0] last_bit(input logic [2:0] w);
        last_bit = (w == 3'h0) ? 3'h7 : w - 3'h1;
    endfunction

    logic tick;
    assign tick = div_reg == 4'(SCK_HALF - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_reg <= '0;
        else if (state_reg == SPISG_IDLE || tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + 4'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_s_reg    <= 1'b0;
            sel_prev_reg <= 1'b0;
        end else begin
            sck_s_reg    <= sck_lvl;
            sel_prev_reg <= sel_act & en & ~mst;
        end
    end

    // word completion strobe for both modes
    logic word_done;
    logic word_shift;
    assign word_shift = mst ? (state_reg == SPISG_TRAIL && tick)
                            : smp_edge;
    // a short final word ends early in slave mode with burst mode 0
    logic       last_word;
    logic [2:0] end_bit;
    assign last_word  = count_reg == 16'h0001;
    assign end_bit    = (!mst && !burst_count_mode && last_word) ?
                        last_bit(width_reg) : 3'h7;
    assign word_done  = word_shift && bit_reg == end_bit;

    // shifter, master fsm and busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SPISG_IDLE;
            shift_reg <= '0;
            bit_reg   <= '0;
            busy_reg  <= 1'b0;
            sck_out   <= 1'b0;
        end else if (!en) begin
            state_reg <= SPISG_IDLE;
            bit_reg   <= '0;
            busy_reg  <= 1'b0;
            sck_out   <= clock_idle_polarity;
        end else if (mst) begin
            case (state_reg)
                SPISG_IDLE: begin
                    sck_out <= clock_idle_polarity;
                    bit_reg <= '0;
                    busy_reg <= go;
                    if (go) begin
                        state_reg <= SPISG_LEAD;
                        shift_reg <= (transmit_path_enable | ~ctrl_reg[CTRL_ECHO]) ?
                                     tx_reg : last_rx_reg;
                    end
                end
                SPISG_LEAD: if (tick) begin
                    sck_out   <= ~clock_idle_polarity;
                    state_reg <= SPISG_TRAIL;
                    shift_reg <= {shift_reg[6:0], pins_s[2]};
                end
                SPISG_TRAIL: if (tick) begin
                    sck_out <= clock_idle_polarity;
                    bit_reg <= bit_reg + 3'h1;
                    state_reg <= (bit_reg == 3'h7) ? SPISG_IDLE
                                                   : SPISG_LEAD;
                end
                default: state_reg <= SPISG_IDLE;
            endcase
        end else begin
            state_reg <= SPISG_IDLE;
            sck_out   <= pins_s[0];
            busy_reg  <= sel_act & (bit_reg != 3'h0);
            if (!sel_act) begin
                bit_reg <= '0;
                // preload while idle so the first bit is out before sck
                if (tx_full_reg)
                    shift_reg <= tx_reg;
            end else if (smp_edge) begin
                shift_reg <= {shift_reg[6:0], pins_s[2]};
                bit_reg   <= word_done ? 3'h0 : bit_reg + 3'h1;
            end
        end
    end

    // serial output pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdo    <= 1'b0;
            sdo_oe <= 1'b0;
            sck_oe <= 1'b0;
        end else begin
            sck_oe <= en;
            if (en && mst) begin
                sdo_oe <= 1'b1;
                sdo    <= shift_reg[7];
            end else if (en && sel_act) begin
                sdo_oe <= 1'b1;
                if (out_edge || bit_reg == 3'h0)
                    sdo <= shift_reg[7];
            end else begin
                sdo_oe <= ~ctrl_reg[CTRL_PIN_DIRECTION_BIT];
                sdo    <= ctrl_reg[CTRL_LAT];
            end
        end
    end

    // fault detection; no interrupt output exists
    // with burst mode 0 a short last word clears the bit count at its final bit, so any
    // nonzero count at select loss is a cut word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fault_reg <= 1'b0;
        else if (sel_drop && !ctrl_reg[CTRL_SELECT_FORCE_ACTIVE] &&
                 bit_reg != 3'h0)
            fault_reg <= 1'b1;
        else if (psel && penable && pwrite && paddr == STAT_OFF &&
                 pwdata[STAT_FAULT])
            fault_reg <= 1'b0;
    end

    // apb access strobes
    logic wr, rd;
    assign wr = psel & penable & pwrite & pready;
    assign rd = psel & penable & ~pwrite & pready;

    // registers, counter and one-word fifos
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= CTRL_RST;
            width_reg   <= WIDTH_RST;
            count_reg   <= COUNT_RST;
            tx_reg      <= '0;
            tx_full_reg <= 1'b0;
            rx_reg      <= '0;
            rx_has_reg  <= 1'b0;
            last_rx_reg <= '0;
        end else begin
            if (wr && paddr == CTRL_OFF)
                ctrl_reg <= pwdata[11:0];
            if (wr && paddr == CONF_OFF)
                width_reg <= pwdata[2:0];
            if (word_done && count_reg != 16'h0000)
                count_reg <= count_reg - 16'h0001;
            else if (wr && paddr == COUNT_OFF)
                count_reg <= pwdata[15:0];
            if (word_done && (transmit_path_enable || !mst))
                tx_full_reg <= 1'b0;
            else if (wr && paddr == TXDAT_OFF) begin
                tx_reg      <= pwdata[7:0];
                tx_full_reg <= 1'b1;
            end
            if (word_done) begin
                last_rx_reg <= {shift_reg[6:0], pins_s[2]};
                if (receive_store_enable || !mst) begin
                    rx_reg     <= {shift_reg[6:0], pins_s[2]};
                    rx_has_reg <= 1'b1;
                end
            end else if (rd && paddr == RXDAT_OFF)
                rx_has_reg <= 1'b0;
            if (!en) begin
                tx_full_reg <= 1'b0;
                rx_has_reg  <= 1'b0;
            end
        end
    end

    // apb read and answer, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr > RXDAT_OFF |
                       paddr[1:0] != 2'b00);
            prdata  <= '0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    CTRL_OFF:  prdata <= {20'h0, ctrl_reg};
                    CONF_OFF:  prdata <= {29'h0, width_reg};
                    STAT_OFF:  prdata <= {27'h0, count_reg == 16'h0,
                                          rx_has_reg, tx_full_reg,
                                          fault_reg, busy_reg};
                    COUNT_OFF: prdata <= {16'h0, count_reg};
                    RXDAT_OFF: prdata <= {24'h0, rx_reg};
                    default:   prdata <= '0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> common/spisg_pkg.sv
// package: constants for the spi select and transfer gating block
package spisg_pkg;
    // apb register byte offsets
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] CONF_OFF   = 8'h04;
    localparam logic [7:0] STAT_OFF   = 8'h08;
    localparam logic [7:0] COUNT_OFF  = 8'h0c;
    localparam logic [7:0] TXDAT_OFF  = 8'h10;
    localparam logic [7:0] RXDAT_OFF  = 8'h14;
    // ctrl bit positions
    localparam int CTRL_EN     = 0;
    localparam int CTRL_MST    = 1;
    localparam int CTRL_TXR    = 2;
    localparam int CTRL_RXR    = 3;
    localparam int CTRL_BURST_COUNT_MODE  = 4;
    localparam int CTRL_SSP    = 5;
    localparam int CTRL_SELECT_FORCE_ACTIVE   = 6;
    localparam int CTRL_CKP    = 7;
    localparam int CTRL_CKE    = 8;
    localparam int CTRL_PIN_DIRECTION_BIT   = 9;
    localparam int CTRL_LAT    = 10;
    localparam int CTRL_ECHO   = 11;
    // ctrl reset value: select active low by default
    localparam logic [11:0] CTRL_RST = 12'h020;
    // conf bit positions: last word width in bits 2:0
    localparam logic [2:0] WIDTH_RST = 3'h0;
    // stat bit positions
    localparam int STAT_BUSY   = 0;
    localparam int STAT_FAULT  = 1;
    localparam int STAT_TXFULL = 2;
    localparam int STAT_RXHAS  = 3;
    localparam int STAT_CZERO  = 4;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    // master clock divider: half period in pclk cycles
    localparam int SCK_HALF = 4;
    typedef enum logic [1:0] {SPISG_IDLE, SPISG_LEAD, SPISG_TRAIL}
        spisg_state_t;
endpackage

// >>> verilog/spisg_sync.sv
// two flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
`default_nettype none
module spisg_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // asynchronous in, synchronous out
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            q_out    <= '0;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// >>> test/spisg_properties.sv
// checker: port assertions for the select and gating block
`timescale 1ns/1ns
`default_nettype none
module spisg_checker
    import spisg_pkg::*;
(
    // apb side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // serial side
    input wire logic        sck_out,
    input wire logic        sdo_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd;
    assign rd = pready && !pwrite && !pslverr;
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access cycle");
    err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    sck_half_a: assert property (
        $changed(sck_out) |=> $stable(sck_out) [*3])
        else $error("serial clock half period too short");
    stat_bits_a: assert property (
        rd && paddr == STAT_OFF |-> prdata[31:5] == 27'h0)
        else $error("status shows unknown flag bits");
    ctrl_bits_a: assert property (
        rd && paddr == CTRL_OFF |-> prdata[31:12] == 20'h0)
        else $error("control read has stray bits");
    count_bits_a: assert property (
        rd && paddr == COUNT_OFF |-> prdata[31:16] == 16'h0)
        else $error("count read wider than sixteen bits");
    cover property (pready && pslverr);
    cover property ($rose(sck_out));
    cover property ($rose(sdo_oe));
endmodule
bind spisg_top spisg_checker chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_out(sck_out), .sdo_oe(sdo_oe));
`default_nettype wire

// >>> test/spisg_ext_master.sv
// model: external spi master driving the block's slave pins
`timescale 1ns/1ns
`default_nettype none
module spisg_ext_master (
    // lines towards the block
    output var  logic sck,
    output var  logic ss_n,
    output var  logic sdi,
    // line from the block
    input  wire logic sdo
);
    initial begin
        sck  = 1'b0;
        ss_n = 1'b1;
        sdi  = 1'b0;
    end
    // clock idles low, sampled on rising edge, msb first
    task automatic frame(input logic [7:0] tx, input int nb,
                         output logic [7:0] rx);
        rx   = 8'h00;
        ss_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            sdi = tx[7-i];
            #160 sck = 1'b1;
            rx = {rx[6:0], sdo};
            #160 sck = 1'b0;
        end
        #160 ss_n = 1'b1;
        sdi = ~sdi;
        #320;
    endtask
endmodule
`default_nettype wire

// >>> test/spisg_top_tb.sv
// bench: self-checking run for the select and gating block
`timescale 1ns/1ns
`default_nettype none
module spisg_top_tb;
    import spisg_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sck_in;
    logic        ss_in;
    logic        sdi;
    logic        sck_out;
    logic        sdo;
    logic        sdo_oe;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  rx;
    int          errors;
    int          n_tests;

    always #20 pclk = ~pclk;

    spisg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck_in(sck_in), .ss_in(ss_in), .sdi(sdi),
        .sck_out(sck_out), .sck_oe(), .sdo(sdo), .sdo_oe(sdo_oe));
    spisg_ext_master mst (.sck(sck_in), .ss_n(ss_in), .sdi(sdi),
        .sdo(sdo));

    task automatic end_of_test;
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1)
            errors++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic frm(input logic [7:0] t, input int nb);
        // link pins move off the sampling edge of pclk
        @(negedge pclk);
        mst.frame(t, nb, rx);
        @(posedge pclk);
    endtask

    task automatic t_reset;
        rchk(CTRL_OFF, 32'hfff, 32'h020);
        apb(1'b0, 8'h18, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
    endtask
    task automatic t_slave;
        wr(CTRL_OFF, 32'h021);
        wr(COUNT_OFF, 32'h1);
        wr(TXDAT_OFF, 32'ha5);
        frm(8'h3c, 8);
        chk({24'h0, rx}, 32'ha5);
        rchk(RXDAT_OFF, 32'hff, 32'h3c);
        rchk(COUNT_OFF, 32'hffff, 32'h0);
        frm(8'h5a, 8);
        chk({24'h0, rx}, 32'h3c);
        rchk(RXDAT_OFF, 32'hff, 32'h5a);
        rchk(STAT_OFF, 32'h2, 32'h0);
    endtask
    task automatic t_fault;
        frm(8'hf0, 4);
        rchk(STAT_OFF, 32'h2, 32'h2);
        wr(STAT_OFF, 32'h2);
        rchk(STAT_OFF, 32'h2, 32'h0);
        wr(CONF_OFF, 32'h3);
        wr(COUNT_OFF, 32'h1);
        frm(8'he0, 3);
        rchk(STAT_OFF, 32'h2, 32'h0);
        rchk(COUNT_OFF, 32'hffff, 32'h0);
        wr(CTRL_OFF, 32'h031);
        frm(8'h0f, 5);
        rchk(STAT_OFF, 32'h2, 32'h2);
        wr(STAT_OFF, 32'h2);
    endtask
    task automatic pin(input logic [31:0] c, input logic [1:0] m,
                       input logic [1:0] e);
        wr(CTRL_OFF, c);
        repeat (3) @(posedge pclk);
        chk({30'h0, {sdo_oe, sdo} & m}, {30'h0, e});
    endtask
    task automatic t_pins;
        pin(32'h221, 2'b10, 2'b00);
        pin(32'h421, 2'b11, 2'b11);
        pin(32'h201, 2'b10, 2'b10);
        pin(32'h261, 2'b10, 2'b10);
    endtask
    task automatic t_master;
        logic seen;
        logic [31:0] modes [3];
        modes = '{32'h023, 32'h02b, 32'h02f};
        seen = 1'b0;
        wr(CTRL_OFF, 32'h023);
        wr(COUNT_OFF, 32'h0);
        wr(TXDAT_OFF, 32'h55);
        foreach (modes[i]) begin
            wr(CTRL_OFF, modes[i]);
            repeat (40) @(posedge pclk);
            chk({31'h0, sck_out}, 32'h0);
            rchk(STAT_OFF, 32'h5, 32'h4);
        end
        wr(COUNT_OFF, 32'h1);
        wr(CTRL_OFF, 32'h027);
        rd = 32'h5;
        for (int i = 0; i < 60 && (rd & 32'h5) != 32'h0; i++) begin
            apb(1'b0, STAT_OFF, 32'h0);
            seen = seen | rd[0];
        end
        chk({31'h0, seen}, 32'h1);
        rchk(COUNT_OFF, 32'hffff, 32'h0);
        wr(TXDAT_OFF, 32'h66);
        repeat (40) @(posedge pclk);
        rchk(STAT_OFF, 32'h5, 32'h4);
        wr(CTRL_OFF, 32'h026);
        rchk(STAT_OFF, 32'h4, 32'h0);
    endtask

    initial begin
        pclk    = 1'b0;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        errors  = 0;
        n_tests = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_slave;
        t_fault;
        t_pins;
        t_master;
        end_of_test;
    end
    initial begin
        #2000000;
        errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
